// File: core/uic_irq_timer.sv
// uart interrupt status, mask and counter/timer with axi4-lite registers
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module uic_irq_timer
	import uic_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic multipurpose_input_pin_in,
	input wire logic break_change_in,
	input wire logic rx_push_in,
	input wire logic rx_read_in,
	input wire logic [1:0] rx_fifo_level_in,
	input wire logic rx_char_waiting_in,
	input wire logic transmitter_empty_flag_in,
	input wire logic transmitter_ready_flag_in,
	input wire logic tx_clk_1x_tick_in,
	output logic irq_out_n,
	output logic multipurpose_output_pin_out
);
	logic rst_meta_reg, rst_n_reg;
	logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
	logic [7:0] aw_addr_reg;
	logic [7:0] w_data_reg;
	logic w_lane0_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	logic [7:0] mask_reg, ctrl_reg, upper_reg, lower_reg;
	logic mpi_level_reg, mpi_chg_reg, brk_chg_reg, ct_ready_reg, rx_stat_reg;
	logic tx_empty_reg, tx_ready_reg, irq_n_reg, mpo_reg, ct_out_reg;
	logic [3:0] clk_div_reg, mpi_div_reg;
	logic [15:0] count_reg;
	uic_ct_state_type ct_state_reg;
	logic [7:0] status_vec;
	logic wr_fire, wr_en, ar_fire, cmd_wr, wr_mapped, rd_mapped;
	logic cmd_start, cmd_stop, cmd_clr_mpi, cmd_clr_brk;
	logic mpi_rise, clk16_tick, mpi16_tick, ct_tick, timer_mode;
	logic ct_active, tc_hit, timer_wrap;
	logic [2:0] mode_f, rx_level_after;
	logic [15:0] preset;

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	// write channel: address and data taken in either order
	assign s_axi_awready_out = !aw_full_reg && !bvalid_reg;
	assign s_axi_wready_out = !w_full_reg && !bvalid_reg;
	assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
	assign wr_en = wr_fire && w_lane0_reg;
	assign wr_mapped = aw_addr_reg[7:2] <= UIC_OFS_CMD[7:2];
	assign cmd_wr = wr_en && aw_addr_reg[7:2] == UIC_OFS_CMD[7:2];
	assign cmd_clr_mpi = cmd_wr && w_data_reg[UIC_CMD_CLR_MPI_CHANGE];
	assign cmd_clr_brk = cmd_wr && w_data_reg[UIC_CMD_CLR_BREAK];
	assign cmd_start = cmd_wr && w_data_reg[UIC_CMD_START];
	assign cmd_stop = cmd_wr && w_data_reg[UIC_CMD_STOP];

	always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 8'h00;
			w_lane0_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= UIC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr_in;
			end else if (wr_fire) begin
				aw_full_reg <= 1'b0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata_in[7:0];
				w_lane0_reg <= s_axi_wstrb_in[0];
			end else if (wr_fire) begin
				w_full_reg <= 1'b0;
			end
			if (wr_fire) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_mapped ? UIC_RESP_OKAY : UIC_RESP_SLVERR;
			end else if (s_axi_bready_in) begin
				bvalid_reg <= 1'b0;
			end
		end
	end
	assign s_axi_bvalid_out = bvalid_reg;
	assign s_axi_bresp_out = bresp_reg;

	// software registers; all fields live in byte lane 0
	always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			mask_reg <= UIC_MASK_RST;
			ctrl_reg <= UIC_CTRL_RST;
			upper_reg <= UIC_UPPER_RST;
			lower_reg <= UIC_LOWER_RST;
		end else if (wr_en) begin
			unique case (aw_addr_reg[7:2])
				UIC_OFS_MASK[7:2]: mask_reg <= w_data_reg;
				UIC_OFS_PRESET_UPPER[7:2]: upper_reg <= w_data_reg;
				UIC_OFS_PRESET_LOWER[7:2]: lower_reg <= w_data_reg;
				UIC_OFS_CTRL[7:2]: ctrl_reg <= w_data_reg;
				default: ;
			endcase
		end
	end
	assign preset = {upper_reg, lower_reg};
	assign mode_f = ctrl_reg[UIC_CTRL_MODE_LSB +: 3];
	assign timer_mode = mode_f[2];

	// status vector, bit 5 unused and reads zero
	assign status_vec = {mpi_chg_reg, mpi_level_reg, 1'b0, ct_ready_reg,
		brk_chg_reg, rx_stat_reg, tx_empty_reg, tx_ready_reg};

	// read channel: status is sampled as the address is taken
	assign s_axi_arready_out = !rvalid_reg;
	assign ar_fire = s_axi_arvalid_in && s_axi_arready_out;
	assign rd_mapped = s_axi_araddr_in[7:2] <= UIC_OFS_CMD[7:2];
	always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= UIC_RESP_OKAY;
		end else if (ar_fire) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= rd_mapped ? UIC_RESP_OKAY : UIC_RESP_SLVERR;
			unique case (s_axi_araddr_in[7:2])
				UIC_OFS_STATUS[7:2]: rdata_reg <= {24'h000000, status_vec};
				UIC_OFS_MASK[7:2]: rdata_reg <= {24'h000000, mask_reg};
				UIC_OFS_PRESET_UPPER[7:2]: rdata_reg <= {24'h000000, upper_reg};
				UIC_OFS_PRESET_LOWER[7:2]: rdata_reg <= {24'h000000, lower_reg};
				UIC_OFS_CTRL[7:2]: rdata_reg <= {24'h000000, ctrl_reg};
				default: rdata_reg <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready_in) begin
			rvalid_reg <= 1'b0;
		end
	end
	assign s_axi_rvalid_out = rvalid_reg;
	assign s_axi_rdata_out = rdata_reg;
	assign s_axi_rresp_out = rresp_reg;

	// pin level and change; sticky flags let a set win over a clear
	assign mpi_rise = multipurpose_input_pin_in && !mpi_level_reg;
	always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			mpi_level_reg <= 1'b0;
			mpi_chg_reg <= 1'b0;
			brk_chg_reg <= 1'b0;
			tx_empty_reg <= 1'b0;
			tx_ready_reg <= 1'b0;
		end else begin
			mpi_level_reg <= multipurpose_input_pin_in;
			if (multipurpose_input_pin_in != mpi_level_reg) begin
				mpi_chg_reg <= 1'b1;
			end else if (cmd_clr_mpi) begin
				mpi_chg_reg <= 1'b0;
			end
			if (break_change_in) begin
				brk_chg_reg <= 1'b1;
			end else if (cmd_clr_brk) begin
				brk_chg_reg <= 1'b0;
			end
			tx_empty_reg <= transmitter_empty_flag_in;
			tx_ready_reg <= transmitter_ready_flag_in;
		end
	end

	// receiver bit; level input counts characters before this cycle's events
	assign rx_level_after = 3'({1'b0, rx_fifo_level_in} + {2'b00, rx_push_in}
		- {2'b00, rx_read_in});
	always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			rx_stat_reg <= 1'b0;
		end else if (!ctrl_reg[UIC_CTRL_RX_SEL]) begin
			if (rx_push_in || rx_read_in) begin
				rx_stat_reg <= rx_level_after != 3'h0;
			end
		end else begin
			if (rx_push_in && rx_level_after == {1'b0, UIC_FIFO_FULL}) begin
				rx_stat_reg <= 1'b1;
			end else if (rx_read_in && !rx_char_waiting_in) begin
				rx_stat_reg <= 1'b0;
			end
		end
	end

	// counter/timer clock sources
	assign clk16_tick = clk_div_reg == UIC_DIV16_LAST;
	assign mpi16_tick = mpi_rise && mpi_div_reg == UIC_DIV16_LAST;
	always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			clk_div_reg <= 4'h0;
			mpi_div_reg <= 4'h0;
		end else begin
			clk_div_reg <= clk_div_reg + 4'h1;
			if (mpi_rise) begin
				mpi_div_reg <= mpi_div_reg + 4'h1;
			end
		end
	end
	always_comb begin
		unique case (mode_f)
			UIC_CT_MPI, UIC_TM_MPI: ct_tick = mpi_rise;
			UIC_CT_MPI16, UIC_TM_MPI16: ct_tick = mpi16_tick;
			UIC_CT_TXC: ct_tick = tx_clk_1x_tick_in;
			UIC_TM_CLK: ct_tick = 1'b1;
			UIC_CT_CLK16, UIC_TM_CLK16: ct_tick = clk16_tick;
		endcase
	end

	// timer runs freely; counter runs between start and stop
	assign ct_active = timer_mode || ct_state_reg == UIC_CT_RUNNING;
	assign timer_wrap = timer_mode && ct_tick && count_reg <= UIC_COUNT_ONE;
	assign tc_hit = !timer_mode && ct_state_reg == UIC_CT_RUNNING && ct_tick
		&& count_reg == UIC_COUNT_ONE;
	always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			ct_state_reg <= UIC_CT_STOPPED;
		end else if (cmd_start) begin
			ct_state_reg <= UIC_CT_RUNNING;
		end else if (cmd_stop) begin
			ct_state_reg <= UIC_CT_STOPPED;
		end
	end
	always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			count_reg <= 16'h0000;
		end else if (cmd_start) begin
			count_reg <= preset;
		end else if (timer_wrap) begin
			count_reg <= preset;
		end else if (ct_tick && ct_active) begin
			count_reg <= count_reg - UIC_COUNT_ONE;
		end
	end
	// the timer output toggles each half-period, so one period is 2x preset
	always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			ct_out_reg <= 1'b1;
		end else if (timer_mode) begin
			if (timer_wrap) begin
				ct_out_reg <= !ct_out_reg;
			end
		end else if (tc_hit) begin
			ct_out_reg <= 1'b0;
		end else if (cmd_stop || cmd_start) begin
			ct_out_reg <= 1'b1;
		end
	end
	always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			ct_ready_reg <= 1'b0;
		end else if (tc_hit || (timer_wrap && ct_out_reg)) begin
			ct_ready_reg <= 1'b1;
		end else if (cmd_stop) begin
			ct_ready_reg <= 1'b0;
		end
	end

	// registered outputs: interrupt and multipurpose pin
	always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			irq_n_reg <= 1'b1;
			mpo_reg <= 1'b1;
		end else begin
			irq_n_reg <= ~|(status_vec & mask_reg);
			unique case (ctrl_reg[UIC_CTRL_MPO_LSB +: 3])
				UIC_MPO_CT: mpo_reg <= ct_out_reg;
				UIC_MPO_TRANSMITTER_READY_FLAG_N: mpo_reg <= !tx_ready_reg;
				UIC_MPO_RX_N: mpo_reg <= !rx_stat_reg;
				default: mpo_reg <= 1'b1;
			endcase
		end
	end
	assign irq_out_n = irq_n_reg;
	assign multipurpose_output_pin_out = mpo_reg;

	sequence s_stop_only;
		cmd_stop && !tc_hit && !(timer_wrap && ct_out_reg);
	endsequence
	sequence s_terminal;
		tc_hit;
	endsequence

	property p_irq_low;
		@(posedge clk_sys_in) disable iff (!rst_n_reg)
		|(status_vec & mask_reg) |=> !irq_out_n;
	endproperty
	a_irq_low: assert property (p_irq_low) else $error("irq not asserted");
	property p_irq_high;
		@(posedge clk_sys_in) disable iff (!rst_n_reg)
		!(|(status_vec & mask_reg)) |=> irq_out_n;
	endproperty
	a_irq_high: assert property (p_irq_high) else $error("irq stuck");
	property p_status_read;
		@(posedge clk_sys_in) disable iff (!rst_n_reg)
		ar_fire && s_axi_araddr_in[7:2] == UIC_OFS_STATUS[7:2]
		|=> s_axi_rvalid_out && s_axi_rdata_out[7:0] == $past(status_vec);
	endproperty
	a_status_read: assert property (p_status_read) else $error("bad status");
	property p_mpi_change;
		@(posedge clk_sys_in) disable iff (!rst_n_reg)
		$changed(multipurpose_input_pin_in) ##1 !cmd_clr_mpi[*2] |=> mpi_chg_reg;
	endproperty
	a_mpi_change: assert property (p_mpi_change) else $error("change lost");
	property p_break_hold;
		@(posedge clk_sys_in) disable iff (!rst_n_reg)
		brk_chg_reg && !cmd_clr_brk |=> brk_chg_reg;
	endproperty
	a_break_hold: assert property (p_break_hold) else $error("break lost");
	property p_terminal;
		@(posedge clk_sys_in) disable iff (!rst_n_reg)
		s_terminal |=> ct_ready_reg && !ct_out_reg;
	endproperty
	a_terminal: assert property (p_terminal) else $error("tc missed");
	property p_stop;
		@(posedge clk_sys_in) disable iff (!rst_n_reg)
		s_stop_only |=> !ct_ready_reg ##1 (!ct_ready_reg || $past(tc_hit)
			|| $past(timer_wrap && ct_out_reg));
	endproperty
	a_stop: assert property (p_stop) else $error("stop ignored");
	property p_timer_reload;
		@(posedge clk_sys_in) disable iff (!rst_n_reg)
		timer_wrap && !cmd_start |=> count_reg == $past(preset);
	endproperty
	a_timer_reload: assert property (p_timer_reload) else $error("reload");
	property p_tx_mirror;
		@(posedge clk_sys_in) disable iff (!rst_n_reg)
		1'b1 |=> tx_ready_reg == $past(transmitter_ready_flag_in)
			&& tx_empty_reg == $past(transmitter_empty_flag_in);
	endproperty
	a_tx_mirror: assert property (p_tx_mirror) else $error("tx mirror");
	property p_mpo_ct;
		@(posedge clk_sys_in) disable iff (!rst_n_reg)
		ctrl_reg[UIC_CTRL_MPO_LSB +: 3] == UIC_MPO_CT
		|=> multipurpose_output_pin_out == $past(ct_out_reg);
	endproperty
	a_mpo_ct: assert property (p_mpo_ct) else $error("mpo wrong");
endmodule : uic_irq_timer
`default_nettype wire

// File: shared/uic_pkg.sv
// constants for the uart interrupt status and counter/timer block
package uic_pkg;
	// register byte offsets
	localparam logic [7:0] UIC_OFS_STATUS = 8'h00;
	localparam logic [7:0] UIC_OFS_MASK = 8'h04;
	localparam logic [7:0] UIC_OFS_PRESET_UPPER = 8'h08;
	localparam logic [7:0] UIC_OFS_PRESET_LOWER = 8'h0C;
	localparam logic [7:0] UIC_OFS_CTRL = 8'h10;
	localparam logic [7:0] UIC_OFS_CMD = 8'h14;
	// interrupt status bit positions
	localparam int UIC_ST_TX_READY = 0;
	localparam int UIC_ST_TX_EMPTY = 1;
	localparam int UIC_ST_RX = 2;
	localparam int UIC_ST_BREAK = 3;
	localparam int UIC_ST_CT_READY = 4;
	localparam int UIC_ST_MPI_LEVEL = 6;
	localparam int UIC_ST_MPI_CHANGE = 7;
	// control register fields
	localparam int UIC_CTRL_MPO_LSB = 0;
	localparam int UIC_CTRL_MODE_LSB = 4;
	localparam int UIC_CTRL_RX_SEL = 7;
	// command register bits, each a write-one pulse
	localparam int UIC_CMD_CLR_MPI_CHANGE = 0;
	localparam int UIC_CMD_CLR_BREAK = 1;
	localparam int UIC_CMD_START = 2;
	localparam int UIC_CMD_STOP = 3;
	// counter/timer mode and source codes; top bit set means timer
	localparam logic [2:0] UIC_CT_MPI = 3'h0;
	localparam logic [2:0] UIC_CT_MPI16 = 3'h1;
	localparam logic [2:0] UIC_CT_TXC = 3'h2;
	localparam logic [2:0] UIC_CT_CLK16 = 3'h3;
	localparam logic [2:0] UIC_TM_MPI = 3'h4;
	localparam logic [2:0] UIC_TM_MPI16 = 3'h5;
	localparam logic [2:0] UIC_TM_CLK = 3'h6;
	localparam logic [2:0] UIC_TM_CLK16 = 3'h7;
	// output pin source codes
	localparam logic [2:0] UIC_MPO_CT = 3'h1;
	localparam logic [2:0] UIC_MPO_TRANSMITTER_READY_FLAG_N = 3'h6;
	localparam logic [2:0] UIC_MPO_RX_N = 3'h7;
	// reset values and counts
	localparam logic [7:0] UIC_MASK_RST = 8'h00;
	localparam logic [7:0] UIC_CTRL_RST = 8'h00;
	localparam logic [7:0] UIC_UPPER_RST = 8'h00;
	localparam logic [7:0] UIC_LOWER_RST = 8'h02;
	localparam logic [3:0] UIC_DIV16_LAST = 4'hF;
	localparam logic [15:0] UIC_COUNT_ONE = 16'h0001;
	localparam logic [1:0] UIC_FIFO_FULL = 2'h3;
	localparam logic [1:0] UIC_RESP_OKAY = 2'h0;
	localparam logic [1:0] UIC_RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		UIC_CT_STOPPED = 2'b01,
		UIC_CT_RUNNING = 2'b10
	} uic_ct_state_type;
endpackage : uic_pkg

// File: test/uic_host_model.sv
// host processor model acting as axi4-lite master on the register port
`timescale 1ns/1ps
`default_nettype none
module uic_host_model (
	input wire logic clk_in,
	output logic [7:0] awaddr_out,
	output logic awvalid_out,
	input wire logic awready_in,
	output logic [31:0] wdata_out,
	output logic [3:0] wstrb_out,
	output logic wvalid_out,
	input wire logic wready_in,
	input wire logic [1:0] bresp_in,
	input wire logic bvalid_in,
	output logic bready_out,
	output logic [7:0] araddr_out,
	output logic arvalid_out,
	input wire logic arready_in,
	input wire logic [31:0] rdata_in,
	input wire logic [1:0] rresp_in,
	input wire logic rvalid_in,
	output logic rready_out
);
	initial begin
		{awaddr_out, araddr_out, wdata_out} = 48'h0;
		{awvalid_out, wvalid_out, bready_out} = 3'h0;
		{arvalid_out, rready_out} = 2'h0;
		wstrb_out = 4'hF;
	end
	// each channel holds until the rising edge that sees its ready high;
	// released payloads are inverted so a late sample shows as a mismatch
	task automatic wr(input logic [7:0] a, input logic [7:0] v,
		output logic [1:0] r);
		@(posedge clk_in);
		awaddr_out <= a;
		wdata_out <= {24'h0, v};
		{awvalid_out, wvalid_out, bready_out} <= 3'h7;
		fork
			begin
				do @(posedge clk_in); while (!awready_in);
				awvalid_out <= 1'b0;
				awaddr_out <= ~a;
			end
			begin
				do @(posedge clk_in); while (!wready_in);
				wvalid_out <= 1'b0;
				wdata_out <= {24'h0, ~v};
			end
		join
		do @(posedge clk_in); while (!bvalid_in);
		r = bresp_in;
		bready_out <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk_in);
		araddr_out <= a;
		{arvalid_out, rready_out} <= 2'h3;
		do @(posedge clk_in); while (!arready_in);
		arvalid_out <= 1'b0;
		araddr_out <= ~a;
		do @(posedge clk_in); while (!rvalid_in);
		d = rdata_in;
		r = rresp_in;
		rready_out <= 1'b0;
	endtask : rd
endmodule : uic_host_model
`default_nettype wire

// File: test/tb_top.sv
// self-checking bench for the interrupt status and counter/timer block
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import uic_pkg::*;
;
	logic clk_sys_in, nrst_in;
	logic [7:0] awaddr, araddr, exp_st, exp_mask;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp, lvl;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, irq_n, multipurpose_output_pin, last;
	logic multipurpose_input_pin, chw, txe, txr;
	logic [3:0] pls;
	// one-cycle event inputs share one vector so a task can pulse them
	wire brk = pls[0];
	wire push = pls[1];
	wire rdp = pls[2];
	wire tick = pls[3];
	localparam logic [3:0] P_BRK = 4'h1;
	localparam logic [3:0] P_PUSH = 4'h2;
	localparam logic [3:0] P_RDP = 4'h4;
	localparam logic [3:0] P_TICK = 4'h8;
	int err_count, num_checks, cnt, p, q, r, k;
	int iv[$];
	uic_irq_timer dut (
		.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .multipurpose_input_pin_in(multipurpose_input_pin),
		.break_change_in(brk), .rx_push_in(push), .rx_read_in(rdp),
		.rx_fifo_level_in(lvl), .rx_char_waiting_in(chw),
		.transmitter_empty_flag_in(txe), .transmitter_ready_flag_in(txr),
		.tx_clk_1x_tick_in(tick), .irq_out_n(irq_n),
		.multipurpose_output_pin_out(multipurpose_output_pin)
	);
	uic_host_model host (
		.clk_in(clk_sys_in), .awaddr_out(awaddr), .awvalid_out(awvalid),
		.awready_in(awready), .wdata_out(wdata), .wstrb_out(wstrb),
		.wvalid_out(wvalid), .wready_in(wready), .bresp_in(bresp),
		.bvalid_in(bvalid), .bready_out(bready), .araddr_out(araddr),
		.arvalid_out(arvalid), .arready_in(arready), .rdata_in(rdata),
		.rresp_in(rresp), .rvalid_in(rvalid), .rready_out(rready)
	);
	initial begin
		clk_sys_in = 1'b0;
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end
	// cycles between output pin edges, kept for period checks
	always @(negedge clk_sys_in) begin
		cnt++;
		if (multipurpose_output_pin !== last) begin
			iv.push_back(cnt);
			cnt = 0;
			last = multipurpose_output_pin;
		end
	end
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		host.wr(a, v, resp);
		chk("bresp", {30'h0, UIC_RESP_OKAY}, {30'h0, resp});
	endtask : wr
	task automatic cmd(input int b);
		wr(UIC_OFS_CMD, 8'h01 << b);
	endtask : cmd
	task automatic pulse(input logic [3:0] m);
		pls <= m;
		@(posedge clk_sys_in);
		pls <= 4'h0;
		@(posedge clk_sys_in);
	endtask : pulse
	// the interrupt line is judged from the model status, never the read
	task automatic chk_st();
		host.rd(UIC_OFS_STATUS, d, resp);
		chk("status", {24'h0, exp_st}, d);
		chk("rresp", {30'h0, UIC_RESP_OKAY}, {30'h0, resp});
		@(negedge clk_sys_in);
		chk("irq_n", {31'h0, ~|(exp_st & exp_mask)}, {31'h0, irq_n});
		@(posedge clk_sys_in);
	endtask : chk_st
	task automatic ctr_run(input int n, input int nxt);
		cmd(UIC_CMD_START);
		wr(UIC_OFS_PRESET_LOWER, nxt[7:0]);
		repeat (n) begin
			@(negedge clk_sys_in);
			chk("ct_out", 1, {31'h0, multipurpose_output_pin});
			@(posedge clk_sys_in);
			pulse(P_TICK);
		end
		@(negedge clk_sys_in);
		chk("ct_out", 0, {31'h0, multipurpose_output_pin});
		@(posedge clk_sys_in);
		pulse(P_TICK);
		exp_st[UIC_ST_CT_READY] = 1'b1;
		chk_st();
		cmd(UIC_CMD_STOP);
		exp_st[UIC_ST_CT_READY] = 1'b0;
		chk_st();
		@(negedge clk_sys_in);
		chk("ct_out", 1, {31'h0, multipurpose_output_pin});
		@(posedge clk_sys_in);
	endtask : ctr_run
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up
	initial begin
		#(25 * 40000);
		err_count++;
		wrap_up();
	end
	initial begin
		void'($urandom(32'h2954));
		{multipurpose_input_pin, chw, txe, txr, pls} = 8'h00;
		{lvl, exp_st, exp_mask} = 18'h0;
		last = 1'b1;
		nrst_in = 1'b0;
		repeat (3) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		repeat (3) @(posedge clk_sys_in);
		chk_st();
		host.rd(UIC_OFS_PRESET_LOWER, d, resp);
		chk("lower reset", {24'h0, UIC_LOWER_RST}, d);
		host.rd(8'h18, d, resp);
		chk("unmapped rresp", {30'h0, UIC_RESP_SLVERR}, {30'h0, resp});
		host.wr(8'h18, 8'h5A, resp);
		chk("unmapped bresp", {30'h0, UIC_RESP_SLVERR}, {30'h0, resp});
		p = $urandom;
		wr(UIC_OFS_MASK, p[7:0]);
		host.rd(UIC_OFS_MASK, d, resp);
		chk("mask", {24'h0, p[7:0]}, d);
		wr(UIC_OFS_MASK, 8'h02);
		exp_mask = 8'h02;
		txr <= 1'b1;
		exp_st[UIC_ST_TX_READY] = 1'b1;
		chk_st();
		txe <= 1'b1;
		exp_st[UIC_ST_TX_EMPTY] = 1'b1;
		chk_st();
		multipurpose_input_pin <= 1'b1;
		exp_st[7:6] = 2'b11;
		chk_st();
		cmd(UIC_CMD_CLR_MPI_CHANGE);
		wr(UIC_OFS_MASK, 8'h40);
		exp_mask = 8'h40;
		exp_st[UIC_ST_MPI_CHANGE] = 1'b0;
		chk_st();
		multipurpose_input_pin <= 1'b0;
		exp_st[7:6] = 2'b10;
		chk_st();
		pulse(P_BRK);
		exp_st[UIC_ST_BREAK] = 1'b1;
		cmd(UIC_CMD_CLR_MPI_CHANGE);
		exp_st[UIC_ST_MPI_CHANGE] = 1'b0;
		chk_st();
		cmd(UIC_CMD_CLR_BREAK);
		exp_st[UIC_ST_BREAK] = 1'b0;
		wr(UIC_OFS_MASK, 8'h04);
		exp_mask = 8'h04;
		pulse(P_PUSH);
		exp_st[UIC_ST_RX] = 1'b1;
		chk_st();
		lvl <= 2'h2;
		pulse(P_RDP);
		chk_st();
		lvl <= 2'h1;
		pulse(P_RDP);
		exp_st[UIC_ST_RX] = 1'b0;
		chk_st();
		wr(UIC_OFS_CTRL, 8'h01 << UIC_CTRL_RX_SEL);
		pulse(P_PUSH);
		chk_st();
		lvl <= 2'h2;
		pulse(P_PUSH);
		exp_st[UIC_ST_RX] = 1'b1;
		chk_st();
		// output pin as inverted receiver bit, then as inverted tx ready
		wr(UIC_OFS_CTRL, 8'h80 | 8'(UIC_MPO_RX_N));
		@(negedge clk_sys_in);
		chk("mpo rx", 0, {31'h0, multipurpose_output_pin});
		wr(UIC_OFS_CTRL, 8'h80 | 8'(UIC_MPO_TRANSMITTER_READY_FLAG_N));
		@(negedge clk_sys_in);
		chk("mpo txr", 0, {31'h0, multipurpose_output_pin});
		@(posedge clk_sys_in);
		{chw, lvl} <= 3'h7;
		pulse(P_RDP);
		chk_st();
		chw <= 1'b0;
		pulse(P_RDP);
		exp_st[UIC_ST_RX] = 1'b0;
		chk_st();
		lvl <= 2'h0;
		p = 2 + $urandom_range(7);
		wr(UIC_OFS_PRESET_LOWER, p[7:0]);
		wr(UIC_OFS_CTRL, {1'b0, UIC_CT_TXC, 1'b0, UIC_MPO_CT});
		wr(UIC_OFS_MASK, 8'h10);
		exp_mask = 8'h10;
		ctr_run(p, p + 1);
		ctr_run(p + 1, p + 1);
		q = 16 + $urandom_range(15);
		r = 16 + $urandom_range(15);
		wr(UIC_OFS_PRESET_LOWER, q[7:0]);
		wr(UIC_OFS_CTRL, {1'b0, UIC_TM_CLK, 1'b0, UIC_MPO_CT});
		cmd(UIC_CMD_START);
		k = iv.size();
		while (iv.size() <= k + 1) @(posedge clk_sys_in);
		@(posedge clk_sys_in);
		iv.delete();
		wr(UIC_OFS_PRESET_LOWER, r[7:0]);
		while (iv.size() <= 2) @(posedge clk_sys_in);
		chk("half period", q, iv[0]);
		chk("period", 2 * r, iv[1] + iv[2]);
		k = iv.size();
		while (iv.size() <= k) @(posedge clk_sys_in);
		@(posedge clk_sys_in);
		cmd(UIC_CMD_STOP);
		host.rd(UIC_OFS_STATUS, d, resp);
		chk("ct_ready", 0, {31'h0, d[UIC_ST_CT_READY]});
		k = iv.size();
		repeat (2 * r + 4) @(posedge clk_sys_in);
		chk("toggles", k + 2, iv.size());
		host.rd(UIC_OFS_STATUS, d, resp);
		chk("ct_ready", 1, {31'h0, d[UIC_ST_CT_READY]});
		@(negedge clk_sys_in);
		chk("irq_n", 0, {31'h0, irq_n});
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
